/* core/tpc_timer.sv */
// Implementation choice: register access over AXI4-Lite.
`timescale 1ns/1ns
`default_nettype none
`include "tpc_defs.svh"
module tpc_timer
  import tpc_pkg::*;
#(
  parameter int CYC_DIV = `TPC_CYC_DIV
) (
  input  wire logic       ref_clk,
  input  wire logic       rstn,
  input  wire logic [7:0] s_axi_awaddr,
  input  wire logic       s_axi_awvalid,
  output logic            s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0] s_axi_wstrb,
  input  wire logic       s_axi_wvalid,
  output logic            s_axi_wready,
  output logic [1:0]      s_axi_bresp,
  output logic            s_axi_bvalid,
  input  wire logic       s_axi_bready,
  input  wire logic [7:0] s_axi_araddr,
  input  wire logic       s_axi_arvalid,
  output logic            s_axi_arready,
  output logic [31:0]     s_axi_rdata,
  output logic [1:0]      s_axi_rresp,
  output logic            s_axi_rvalid,
  input  wire logic       s_axi_rready,
  input  wire logic       external_count_input,
  input  wire logic       compare_raw,
  input  wire logic       watchdog_osc,
  output logic            comparator_output_line,
  output logic            shared_output_pin_out,
  output logic            shared_output_pin_oe,
  output logic            shared_output_pin_input,
  output logic            comparator_enable,
  output logic            negative_reference_select,
  output logic            positive_reference_select,
  output logic            compare_wake,
  output logic            watchdog_tick,
  output logic            watchdog_clear_op
);
  tpc_setup_t   setup;
  tpc_cmp_ctl_t cmp_ctl;
  logic [7:0]   timer_count;
  logic [1:0]   inhibit_cnt;
  logic [$clog2(CYC_DIV)-1:0] cyc_cnt;
  logic         cyc_en;

  // cycle divider
  assign cyc_en = (cyc_cnt == ($clog2(CYC_DIV))'(CYC_DIV - 1));

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      cyc_cnt <= '0;
    end else begin
      cyc_cnt <= cyc_en ? '0 : cyc_cnt + 1'b1;
    end
  end

  // pin-side inputs
  logic [2:0] sync_lvl;
  tpc_sync3 #(.W(3)) u_sync (
    .ref_clk  (ref_clk),
    .rstn     (rstn),
    .async_in ({watchdog_osc, compare_raw, external_count_input}),
    .level    (sync_lvl)
  );

  logic pin_q;
  logic line_q;
  logic wdo_q;
  logic cmp_on;
  logic cmp_res;
  logic pin_edge;
  logic line_edge;
  logic wdt_edge;

  assign cmp_on  = cmp_ctl.comparator_on;
  assign cmp_res = cmp_on & sync_lvl[1];
  assign comparator_output_line = cmp_res ^ ~cmp_ctl.output_polarity & cmp_on;

  // edge_select 0 -> rising, 1 -> falling
  assign pin_edge  = setup.edge_select ? (pin_q & ~sync_lvl[0])
                                       : (~pin_q & sync_lvl[0]);
  assign line_edge = setup.edge_select ? (line_q & ~comparator_output_line)
                                       : (~line_q & comparator_output_line);
  assign wdt_edge  = ~wdo_q & sync_lvl[2];

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      pin_q  <= 1'b0;
      line_q <= 1'b0;
      wdo_q  <= 1'b0;
    end else begin
      pin_q  <= sync_lvl[0];
      line_q <= comparator_output_line;
      wdo_q  <= sync_lvl[2];
    end
  end

  // wake pulse only while comparator runs and wake is enabled
  assign compare_wake = cmp_on & ~cmp_ctl.compare_wake_disable
                        & (line_q ^ comparator_output_line);

  // timer source: comparator bits count only while it is on
  tpc_src_t src;
  logic     src_tick;
  assign src = (cmp_on && !cmp_ctl.compare_as_timer_clock) ? TPC_SRC_COMPARE
             : setup.count_source_select ? TPC_SRC_PIN : TPC_SRC_CYCLE;
  assign src_tick = (src == TPC_SRC_COMPARE) ? line_edge
                  : (src == TPC_SRC_PIN) ? pin_edge : cyc_en;

  // shared prescaler
  logic pre_in;
  logic pre_out;
  logic pre_clr;
  logic timer_adv;
  logic wr_timer;
  logic wr_cmp;
  logic wr_setup;
  logic wr_wdt;
  logic [7:0] wdat;

  assign pre_in        = setup.prescaler_assign ? wdt_edge : src_tick;
  assign timer_adv     = setup.prescaler_assign ? src_tick : pre_out;
  assign watchdog_tick = setup.prescaler_assign ? pre_out : wdt_edge;
  // a timer write also restarts the prescaler when it belongs to the timer
  assign pre_clr = watchdog_clear_op | (wr_timer & ~setup.prescaler_assign);

  tpc_prescaler u_pre (
    .ref_clk  (ref_clk),
    .rstn     (rstn),
    .tick     (pre_in),
    .clear    (pre_clr),
    .ratio    (setup.prescale_ratio),
    .out_tick (pre_out)
  );

  // counter with post-write hold-off
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      timer_count <= `TPC_RST_TIMER_COUNT;
      inhibit_cnt <= 2'd0;
    end else if (wr_timer) begin
      timer_count <= wdat;
      inhibit_cnt <= `TPC_WR_INHIBIT;
    end else begin
      if (cyc_en && inhibit_cnt != 2'd0) begin
        inhibit_cnt <= inhibit_cnt - 2'd1;
      end
      if (timer_adv && inhibit_cnt == 2'd0) begin
        timer_count <= timer_count + 8'h01;
      end
    end
  end

  // pin and analog control outputs
  assign shared_output_pin_oe    = cmp_on & ~cmp_ctl.compare_pin_disable;
  assign shared_output_pin_out   = comparator_output_line;
  assign shared_output_pin_input = ~shared_output_pin_oe & setup.count_source_select;
  assign comparator_enable         = cmp_on;
  assign negative_reference_select = cmp_on & cmp_ctl.negative_reference_select;
  assign positive_reference_select = cmp_on & cmp_ctl.positive_reference_select;

  // register bus: write path, address and data in either order
  logic       aw_hold;
  logic       w_hold;
  logic [5:0] aw_idx;
  logic [7:0] w_data;
  logic       w_lane0;
  logic       do_wr;
  logic       wr_map;

  assign s_axi_awready = ~aw_hold & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_hold & ~s_axi_bvalid;
  assign do_wr  = aw_hold & w_hold & ~s_axi_bvalid;
  assign wr_map = (aw_idx == `TPC_IDX_TIMER_COUNT) || (aw_idx == `TPC_IDX_CMP_CONTROL)
               || (aw_idx == `TPC_IDX_TIMER_SETUP) || (aw_idx == `TPC_IDX_WDT_CONTROL);
  assign wdat     = w_data;
  // no index reaches the prescaler count
  assign wr_timer = do_wr & w_lane0 & (aw_idx == `TPC_IDX_TIMER_COUNT);
  assign wr_cmp   = do_wr & w_lane0 & (aw_idx == `TPC_IDX_CMP_CONTROL);
  assign wr_setup = do_wr & w_lane0 & (aw_idx == `TPC_IDX_TIMER_SETUP);
  assign wr_wdt   = do_wr & w_lane0 & (aw_idx == `TPC_IDX_WDT_CONTROL);

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      aw_hold <= 1'b0;
      w_hold  <= 1'b0;
      aw_idx  <= 6'h00;
      w_data  <= 8'h00;
      w_lane0 <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold <= 1'b1;
        aw_idx  <= s_axi_awaddr[7:2];
      end else if (do_wr) begin
        aw_hold <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold  <= 1'b1;
        w_data  <= s_axi_wdata[7:0];
        w_lane0 <= s_axi_wstrb[0];
      end else if (do_wr) begin
        w_hold <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `TPC_RESP_OKAY;
    end else if (do_wr) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_map ? `TPC_RESP_OKAY : `TPC_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // control registers; bit 7 of comparator control is live status
  logic [6:0] cmp_bits;
  // status bit gated from the stored enable so cmp_on never loops through cmp_ctl
  assign cmp_ctl = {sync_lvl[1] & cmp_bits[3], cmp_bits};

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      setup             <= `TPC_RST_TIMER_SETUP;
      cmp_bits          <= 7'(`TPC_RST_CMP_CONTROL);
      watchdog_clear_op <= 1'b0;
    end else begin
      if (wr_setup) begin
        setup <= wdat;
      end
      if (wr_cmp) begin
        cmp_bits <= 7'(wdat & `TPC_CMP_RW_MASK);
      end
      watchdog_clear_op <= wr_wdt & wdat[`TPC_WDT_CLEAR_BIT];
    end
  end

  // register bus: read path
  logic [5:0] ar_idx;
  logic [7:0] rd_val;
  logic       rd_map;
  assign s_axi_arready = ~s_axi_rvalid;
  assign ar_idx = s_axi_araddr[7:2];
  assign rd_map = (ar_idx == `TPC_IDX_TIMER_COUNT) || (ar_idx == `TPC_IDX_CMP_CONTROL)
               || (ar_idx == `TPC_IDX_TIMER_SETUP) || (ar_idx == `TPC_IDX_WDT_CONTROL);
  assign rd_val = (ar_idx == `TPC_IDX_TIMER_COUNT) ? timer_count
                : (ar_idx == `TPC_IDX_CMP_CONTROL) ? cmp_ctl
                : (ar_idx == `TPC_IDX_TIMER_SETUP) ? setup : 8'h00;

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= `TPC_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= {24'h000000, rd_val};
      s_axi_rresp  <= rd_map ? `TPC_RESP_OKAY : `TPC_RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // checks
  property p_cycle_count;
    @(posedge ref_clk) disable iff (!rstn)
    (src == TPC_SRC_CYCLE && setup.prescaler_assign && cyc_en && inhibit_cnt == 2'd0
     && !wr_timer) |=> (timer_count == $past(timer_count) + 8'h01);
  endproperty
  a_cycle_count: assert property (p_cycle_count)
    else $error("timer missed an instruction cycle");

  property p_write_hold;
    @(posedge ref_clk) disable iff (!rstn)
    (wr_timer ##1 !wr_timer [*3]) |-> (timer_count == $past(timer_count, 2));
  endproperty
  a_write_hold: assert property (p_write_hold)
    else $error("timer moved right after a write");

  property p_pin_edge;
    @(posedge ref_clk) disable iff (!rstn)
    (src == TPC_SRC_PIN && $fell(sync_lvl[0]) && $past(setup.edge_select)
     && setup.edge_select) |-> $past(pin_edge) == 1'b0 ##0 pin_edge;
  endproperty
  a_pin_edge: assert property (p_pin_edge)
    else $error("falling pin edge not seen");

  property p_assign;
    @(posedge ref_clk) disable iff (!rstn)
    setup.prescaler_assign |-> (timer_adv == src_tick) && (pre_in == wdt_edge);
  endproperty
  a_assign: assert property (p_assign)
    else $error("prescaler shared by both users");

  property p_ratio;
    @(posedge ref_clk) disable iff (!rstn)
    (!setup.prescaler_assign && setup.prescale_ratio == 3'd0 && pre_out)
    |=> !pre_out;
  endproperty
  a_ratio: assert property (p_ratio)
    else $error("divide by two produced back to back ticks");

  property p_status_bit;
    @(posedge ref_clk) disable iff (!rstn)
    (s_axi_arvalid && s_axi_arready && ar_idx == `TPC_IDX_CMP_CONTROL)
    |=> s_axi_rdata[7] == $past(cmp_on & sync_lvl[1]);
  endproperty
  a_status_bit: assert property (p_status_bit)
    else $error("compare result read back wrong");

  property p_pin_drive;
    @(posedge ref_clk) disable iff (!rstn)
    shared_output_pin_oe |-> cmp_on && !cmp_ctl.compare_pin_disable
                             && !shared_output_pin_input;
  endproperty
  a_pin_drive: assert property (p_pin_drive)
    else $error("shared pin driven while disabled");

  property p_off;
    @(posedge ref_clk) disable iff (!rstn)
    !cmp_on |-> !shared_output_pin_oe && !compare_wake && src != TPC_SRC_COMPARE;
  endproperty
  a_off: assert property (p_off)
    else $error("comparator bits acted while off");

  property p_wrap;
    @(posedge ref_clk) disable iff (!rstn)
    (timer_count == 8'hFF && timer_adv && inhibit_cnt == 2'd0 && !wr_timer)
    |=> timer_count == 8'h00;
  endproperty
  a_wrap: assert property (p_wrap)
    else $error("timer did not wrap to zero");
endmodule // tpc_timer
`default_nettype wire

/* core/tpc_defs.svh */
`ifndef TPC_DEFS_SVH
`define TPC_DEFS_SVH

// register indexes; byte address is four times the index
`define TPC_IDX_TIMER_COUNT  6'h01
`define TPC_IDX_CMP_CONTROL  6'h07
`define TPC_IDX_TIMER_SETUP  6'h08
`define TPC_IDX_WDT_CONTROL  6'h09

// reset values
`define TPC_RST_TIMER_COUNT  8'h00
`define TPC_RST_CMP_CONTROL  8'hFF
`define TPC_RST_TIMER_SETUP  8'hFF

// comparator control: bit 7 is read-only
`define TPC_CMP_RW_MASK      8'h7F
// watchdog control: write-1 clear strobe position
`define TPC_WDT_CLEAR_BIT    0

// instruction cycle = this many ref_clk periods
`define TPC_CYC_DIV          4
// cycles with counting held off after a timer_count write
`define TPC_WR_INHIBIT       2'd2

`define TPC_RESP_OKAY        2'h0
`define TPC_RESP_SLVERR      2'h2

`endif

/* core/tpc_pkg.sv */
`default_nettype none
package tpc_pkg;

  typedef struct packed {
    logic       wake_pin_disable;
    logic       pullup_disable;
    logic       count_source_select;
    logic       edge_select;
    logic       prescaler_assign;
    logic [2:0] prescale_ratio;
  } tpc_setup_t;

  typedef struct packed {
    logic compare_result;
    logic compare_pin_disable;
    logic output_polarity;
    logic compare_as_timer_clock;
    logic comparator_on;
    logic negative_reference_select;
    logic positive_reference_select;
    logic compare_wake_disable;
  } tpc_cmp_ctl_t;

  typedef enum logic [1:0] {
    TPC_SRC_CYCLE,
    TPC_SRC_PIN,
    TPC_SRC_COMPARE
  } tpc_src_t;

endpackage
`default_nettype wire

/* core/tpc_sync3.sv */
`timescale 1ns/1ns
`default_nettype none
module tpc_sync3
  import tpc_pkg::*;
#(
  parameter int W = 1
) (
  input  wire logic         ref_clk,
  input  wire logic         rstn,
  input  wire logic [W-1:0] async_in,
  output var  logic [W-1:0] level
);
  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;

  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      // level moves only once the second and third stages agree
      always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
          s1[i]    <= 1'b0;
          s2[i]    <= 1'b0;
          s3[i]    <= 1'b0;
          level[i] <= 1'b0;
        end else begin
          s1[i] <= async_in[i];
          s2[i] <= s1[i];
          s3[i] <= s2[i];
          if (s2[i] == s3[i]) begin
            level[i] <= s3[i];
          end
        end
      end
    end
  endgenerate
endmodule // tpc_sync3
`default_nettype wire

/* core/tpc_prescaler.sv */
`timescale 1ns/1ns
`default_nettype none
module tpc_prescaler
  import tpc_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       rstn,
  input  wire logic       tick,
  input  wire logic       clear,
  input  wire logic [2:0] ratio,
  output logic            out_tick
);
  logic [7:0] count;
  logic [7:0] next_count;
  logic [7:0] mask;

  // ratio 0 divides by 2, ratio 7 by 256
  assign mask       = 8'hFF >> (3'd7 - ratio);
  assign next_count = count + 8'h01;
  assign out_tick   = tick && ((next_count & mask) == 8'h00);

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      count <= 8'h00;
    end else if (clear) begin
      count <= 8'h00;
    end else if (tick) begin
      count <= next_count;
    end
  end
endmodule // tpc_prescaler
`default_nettype wire

/* verification/tpc_timer_tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
`include "tpc_defs.svh"
module tpc_timer_tb_top
  import tpc_pkg::*;
;
  localparam int DIV = 4;
  localparam int LIMIT = 40000;
  localparam logic [7:0] A_TC = {`TPC_IDX_TIMER_COUNT, 2'b00};
  localparam logic [7:0] A_CC = {`TPC_IDX_CMP_CONTROL, 2'b00};
  localparam logic [7:0] A_SU = {`TPC_IDX_TIMER_SETUP, 2'b00};
  localparam logic [7:0] A_WD = {`TPC_IDX_WDT_CONTROL, 2'b00};
  localparam logic [1:0] OK = `TPC_RESP_OKAY;
  localparam logic [1:0] ERR = `TPC_RESP_SLVERR;

  typedef struct packed {
    logic [7:0] a;
    logic [7:0] wd;
    logic       raw;
    logic [7:0] rd;
    logic [1:0] rs;
    logic [5:0] pins;
  } tpc_row_t;
  typedef struct packed {
    logic [7:0] su;
    logic [7:0] cc;
    logic       raw;
    logic [7:0] n;
  } tpc_cnt_t;

  // pins = {output line, pin drive, pin input, enable, negative sel, positive sel}
  localparam tpc_row_t ROWS [8] = '{
    '{A_SU, 8'hE8, 1'b0, 8'hE8, OK, 6'h0F}, '{A_CC, 8'h08, 1'b1, 8'h88, OK, 6'h14},
    '{A_CC, 8'h2E, 1'b1, 8'hAE, OK, 6'h37}, '{A_CC, 8'h6F, 1'b0, 8'h6F, OK, 6'h0F},
    '{A_CC, 8'h76, 1'b1, 8'h76, OK, 6'h08}, '{A_CC, 8'h06, 1'b1, 8'h06, OK, 6'h08},
    '{8'h3C, 8'h55, 1'b1, 8'h00, ERR, 6'h08}, '{A_CC, 8'hF7, 1'b1, 8'h77, OK, 6'h08}};
  localparam tpc_cnt_t CNT [4] = '{'{8'hE8, 8'h7F, 1'b0, 8'h03}, '{8'hF8, 8'h7F, 1'b0, 8'h02},
    '{8'hE8, 8'h28, 1'b1, 8'h03}, '{8'hE8, 8'h20, 1'b0, 8'h03}};
  localparam logic [7:0] RA [3] = '{A_SU, A_CC, A_TC};
  localparam logic [7:0] RV [3] = '{`TPC_RST_TIMER_SETUP,
    `TPC_RST_CMP_CONTROL & `TPC_CMP_RW_MASK, `TPC_RST_TIMER_COUNT};

  logic        ref_clk, rstn;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready;
  logic        external_count_input, compare_raw, watchdog_osc;
  logic        comparator_output_line, shared_output_pin_oe, shared_output_pin_input;
  logic        shared_output_pin_out;
  logic        comparator_enable, negative_reference_select, positive_reference_select;
  logic        compare_wake, watchdog_tick, watchdog_clear_op;
  logic [7:0]  v1, v2;
  int          n_mismatch = 0, comparisons = 0, cyc = 0;
  int          n_wake = 0, n_wd = 0, n_clr = 0, t1, t2, w;

  tpc_timer #(.CYC_DIV(DIV)) DUT (
    .ref_clk, .rstn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .external_count_input, .compare_raw, .watchdog_osc,
    .comparator_output_line, .shared_output_pin_out, .shared_output_pin_oe,
    .shared_output_pin_input, .comparator_enable, .negative_reference_select,
    .positive_reference_select, .compare_wake, .watchdog_tick, .watchdog_clear_op);

  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // pulse counters also carry the hang guard
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (compare_wake === 1'b1) n_wake <= n_wake + 1;
    if (watchdog_tick === 1'b1) n_wd <= n_wd + 1;
    if (watchdog_clear_op === 1'b1) n_clr <= n_clr + 1;
    if (cyc == LIMIT) begin
      n_mismatch = n_mismatch + 1;
      tally_and_finish();
    end
  end

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic [1:0] resp);
    @(posedge ref_clk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= {24'h000000, d};
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  // t is the cycle at which the address was taken, used to space two samples
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output int t);
    @(posedge ref_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arvalid <= 1'b0;
        t = cyc;
      end
    end while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata[7:0];
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  // spacing a multiple of the instruction cycle makes the count difference exact
  task automatic span(input int ta, input int d);
    #1;
    while (!((cyc + 1 - ta) % DIV == 0 && cyc + 1 - ta >= d)) begin
      @(posedge ref_clk);
      #1;
    end
  endtask

  task automatic toggles(input int n, input int which);
    repeat (n) begin
      repeat (8) @(posedge ref_clk);
      case (which)
        0: external_count_input <= ~external_count_input;
        1: compare_raw <= ~compare_raw;
        default: watchdog_osc <= ~watchdog_osc;
      endcase
    end
    repeat (8) @(posedge ref_clk);
  endtask

  task automatic reset_and_check;
    rstn <= 1'b0;
    repeat (20) @(posedge ref_clk);
    rstn <= 1'b1;
    for (int k = 0; k < 3; k++) begin
      rd(RA[k], v1, t1);
      check("reset value", v1, RV[k]);
    end
  endtask

  initial begin
    rstn = 1'b0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hF;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {external_count_input, compare_raw, watchdog_osc} = '0;
    reset_and_check();
    foreach (ROWS[i]) begin
      @(posedge ref_clk);
      compare_raw <= ROWS[i].raw;
      wr(ROWS[i].a, ROWS[i].wd, rs);
      check("bresp", rs, ROWS[i].rs);
      repeat (8) @(posedge ref_clk);
      rd(ROWS[i].a, v1, t1);
      check("rdata", v1, ROWS[i].rd);
      check("rresp", rs, ROWS[i].rs);
      check("pins", {comparator_output_line, shared_output_pin_oe, shared_output_pin_input,
        comparator_enable, negative_reference_select, positive_reference_select},
        ROWS[i].pins);
      check("pin out", shared_output_pin_out, ROWS[i].pins[5]);
    end
    @(posedge ref_clk);
    compare_raw <= 1'b0;
    foreach (CNT[i]) begin
      wr(A_SU, CNT[i].su, rs);
      wr(A_CC, CNT[i].cc, rs);
      wr(A_TC, 8'h00, rs);
      repeat (16) @(posedge ref_clk);
      rd(A_TC, v1, t1);
      toggles(5, int'(CNT[i].raw));
      rd(A_TC, v2, t2);
      check("edge count", 8'(v2 - v1), CNT[i].n);
      toggles(1, int'(CNT[i].raw));
    end
    wr(A_CC, 8'h7F, rs);
    wr(A_SU, 8'hC8, rs);
    wr(A_TC, 8'hF8, rs);
    repeat (16) @(posedge ref_clk);
    rd(A_TC, v1, t1);
    span(t1, 40);
    rd(A_TC, v2, t2);
    check("cycle count", 8'(v2 - v1), 8'((t2 - t1) / DIV));
    wr(A_TC, 8'h40, rs);
    rd(A_TC, v1, t1);
    check("held after write", v1, 8'h40);
    span(t1, 8 * DIV);
    rd(A_TC, v2, t2);
    check("resume after hold", (v2 === 8'(v1 + 6)) || (v2 === 8'(v1 + 7)), 1'b1);
    for (int r = 0; r < 8; r++) begin
      wr(A_SU, {5'h18, 3'(r)}, rs);
      wr(A_TC, 8'h00, rs);
      repeat (16) @(posedge ref_clk);
      rd(A_TC, v1, t1);
      span(t1, 3 * DIV * (2 << r));
      rd(A_TC, v2, t2);
      check("prescaled count", 8'(v2 - v1), 8'h03);
    end
    for (int k = 0; k < 2; k++) begin
      wr(A_CC, 8'h2E | 8'(k), rs);
      w = n_wake;
      toggles(2, 1);
      check("wake pulses", n_wake - w, 2 - 2 * k);
    end
    wr(A_SU, 8'hE8, rs);
    w = n_clr;
    wr(A_WD, 8'h01, rs);
    repeat (2) @(posedge ref_clk);
    check("watchdog clear", n_clr - w, 1);
    for (int k = 0; k < 2; k++) begin
      // second pass hands the prescaler back to the timer, so every rising edge ticks
      if (k == 1) begin
        // clear watchdog and prescaler before handing the prescaler over
        wr(A_WD, 8'h01, rs);
        wr(A_SU, 8'hE0, rs);
      end
      w = n_wd;
      toggles(16, 2);
      check("watchdog ticks", n_wd - w, 4 + 4 * k);
    end
    reset_and_check();
    tally_and_finish();
  end
endmodule // tpc_timer_tb_top
`default_nettype wire
